//--- design/pac_classifier.sv
// Physical-address classifier: DRAM versus MMIO routing, encrypt-bit handling, checks
`timescale 1ns/1ns
`default_nettype none
`include "pac_params.svh"
module pac_classifier
	import pac_pkg::*;
#(
	parameter int NPAIR     = `PAC_NUM_PAIRS,
	parameter int CBIT_POS  = `PAC_CBIT_POS,
	parameter int FULL_PA_W = `PAC_FULL_PA_W,
	parameter int RED_PA_W  = `PAC_RED_PA_W,
	parameter bit REDUCE_W  = 1'b1,
	parameter bit COHERENT  = 1'b0
) (
	input  wire logic                   i_clk,
	input  wire logic                   i_resetn,
	input  wire logic                   i_entropy,
	input  wire logic                   i_cfg_we,
	input  wire logic [63:0]            i_cfg_wdata,
	input  wire logic                   i_low_we,
	input  wire logic                   i_high_we,
	input  wire logic [63:0]            i_bnd_wdata,
	input  wire logic [NPAIR-1:0]       i_base_we,
	input  wire logic [NPAIR-1:0]       i_mask_we,
	input  wire logic [63:0]            i_pair_wdata,
	input  wire logic                   i_req_valid,
	input  wire logic [63:0]            i_req_addr,
	input  wire logic                   i_req_write,
	input  wire logic                   i_req_cbit,
	input  wire logic [1:0]             i_req_page,
	input  wire logic [2:0]             i_req_type,
	input  wire logic                   i_addr_ext_on,
	input  wire logic                   i_paging_on,
	input  wire logic                   i_legacy_32,
	input  wire logic                   i_mgmt_mode,
	output logic [63:0]                 o_cfg_rdata,
	output logic [63:0]                 o_low_rdata,
	output logic [63:0]                 o_high_rdata,
	output logic [31:0]                 o_feat_eax,
	output logic [31:0]                 o_feat_ebx,
	output logic                        o_req_ready,
	output logic                        o_rsp_valid,
	output logic                        o_rsp_dram,
	output logic                        o_rsp_encrypt,
	output logic                        o_rsp_next_enc,
	output logic                        o_rsp_type_bad,
	output logic                        o_rsp_pf,
	output logic                        o_rsp_mce,
	output logic [`PAC_ADDR_W-1:0]      o_rsp_addr,
	output logic                        o_key_ready,
	output logic [`PAC_KEY_W-1:0]       o_key
);
	typedef struct packed {
		pac_state_t                  st;
		logic [63:0]                 cfg;
		logic [`PAC_BND_HI:`PAC_BND_LO] low;
		logic [`PAC_BND_HI:`PAC_BND_LO] high;
		logic [NPAIR-1:0][`PAC_BND_HI:`PAC_RANGE_LO] base;
		logic [NPAIR-1:0][`PAC_BND_HI:`PAC_RANGE_LO] mask;
		logic [NPAIR-1:0]            rd_t;
		logic [NPAIR-1:0]            wr_t;
		logic [NPAIR-1:0]            vld;
		logic                        dram;
		logic                        enc;
		logic                        nxt_enc;
		logic                        type_bad;
		logic                        pf;
		logic                        mce;
		logic [`PAC_ADDR_W-1:0]      addr;
	} pac_state_all_t;

	pac_state_all_t s_r;
	pac_state_all_t s_nxt;

	// ==========================================================
	// Helper functions
	// Allowed target/type combinations; anything else is flagged for the core
	function automatic logic type_ok(input logic rd, input logic wr, input logic [2:0] ty);
		logic ok;
		ok = 1'b0;
		case ({rd, wr})
			2'b00: ok = (ty == `PAC_TYPE_UC) || (ty == `PAC_TYPE_WC) ||
				(ty == `PAC_TYPE_WT) || (ty == `PAC_TYPE_WP);
			2'b01: ok = (ty == `PAC_TYPE_UC) || (ty == `PAC_TYPE_WC);
			2'b10: ok = (ty == `PAC_TYPE_UC) || (ty == `PAC_TYPE_WP);
			2'b11: ok = (ty == `PAC_TYPE_UC) || (ty == `PAC_TYPE_WC) ||
				(ty == `PAC_TYPE_WT) || (ty == `PAC_TYPE_WB);
			default: ok = 1'b0;
		endcase
		return ok;
	endfunction

	// Effective physical width; reduction applies only with encryption on
	function automatic int eff_width(input logic enc_on);
		return (enc_on && REDUCE_W) ? RED_PA_W : FULL_PA_W;
	endfunction

	// ==========================================================
	// Lookup datapath
	logic                        enc_on;
	logic                        mode_ok;
	logic [`PAC_ADDR_W-1:0]      pa;
	logic [`PAC_ADDR_W-1:0]      upper_bits;
	logic                        below_low;
	logic                        in_high;
	logic                        bnd_dram;
	logic                        pair_hit;
	logic                        pair_dram;
	logic                        pair_rd;
	logic                        pair_wr;
	logic                        dram_sel;
	logic                        enc_page;

	// Encryption path exists only with address extension and paging, also in management mode
	assign mode_ok = i_addr_ext_on && i_paging_on;
	assign enc_on  = s_r.cfg[`PAC_CFG_ENC_EN] && mode_ok;

	// Encrypt bit masked and width clipped before any range compare
	always_comb begin
		int w;
		w = eff_width(enc_on);
		pa = '0;
		upper_bits = '0;
		for (int b = 0; b < `PAC_ADDR_W; b++) begin
			if (b < w) begin
				pa[b] = i_req_addr[b];
			end else begin
				upper_bits[b] = i_req_addr[b];
			end
		end
		if (enc_on && CBIT_POS < `PAC_ADDR_W) begin
			pa[CBIT_POS] = 1'b0;
			upper_bits[CBIT_POS] = 1'b0;
		end
	end

	// Boundary classification; disabled boundaries fall through to MMIO
	always_comb begin
		below_low = (pa[`PAC_ADDR_W-1:`PAC_4G_BIT] == '0) &&
			(pa[`PAC_BND_HI:`PAC_BND_LO] < s_r.low);
		in_high = (pa[`PAC_ADDR_W-1:`PAC_4G_BIT] != '0) &&
			(pa[`PAC_BND_HI:`PAC_BND_LO] < s_r.high);
		bnd_dram = (s_r.cfg[`PAC_CFG_LOW_EN] && below_low) ||
			(s_r.cfg[`PAC_CFG_HIGH_EN] && in_high);
	end

	// Range pairs: lowest-numbered valid hit wins on overlap
	always_comb begin
		pair_hit = 1'b0;
		pair_rd  = 1'b0;
		pair_wr  = 1'b0;
		for (int p = NPAIR - 1; p >= 0; p--) begin
			if (s_r.vld[p] &&
				((pa[`PAC_BND_HI:`PAC_RANGE_LO] & s_r.mask[p]) ==
				(s_r.base[p] & s_r.mask[p]))) begin
				pair_hit = 1'b1;
				pair_rd  = s_r.rd_t[p];
				pair_wr  = s_r.wr_t[p];
			end
		end
		pair_dram = i_req_write ? pair_wr : pair_rd;
	end

	assign dram_sel = pair_hit ? pair_dram : bnd_dram;
	// Any page size carries the bit; upper entries mark the next table encrypted
	assign enc_page = enc_on && i_req_cbit;

	// ==========================================================
	// Register file and lookup sequence
	always_comb begin
		s_nxt = s_r;
		if (i_cfg_we) begin
			s_nxt.cfg = i_cfg_wdata;
		end
		// Only the aligned address field is stored, the rest is ignored
		if (i_low_we) begin
			s_nxt.low = i_bnd_wdata[`PAC_BND_HI:`PAC_BND_LO];
		end
		if (i_high_we) begin
			s_nxt.high = i_bnd_wdata[`PAC_BND_HI:`PAC_BND_LO];
		end
		for (int p = 0; p < NPAIR; p++) begin
			if (i_base_we[p]) begin
				s_nxt.base[p] = i_pair_wdata[`PAC_BND_HI:`PAC_RANGE_LO];
				s_nxt.wr_t[p] = i_pair_wdata[`PAC_WR_BIT];
				s_nxt.rd_t[p] = i_pair_wdata[`PAC_RD_BIT];
			end
			if (i_mask_we[p]) begin
				s_nxt.mask[p] = i_pair_wdata[`PAC_BND_HI:`PAC_RANGE_LO];
				s_nxt.vld[p]  = i_pair_wdata[`PAC_VALID_BIT];
			end
		end
		case (s_r.st)
			PAC_ST_IDLE,
			PAC_ST_DONE: begin
				s_nxt.st = PAC_ST_IDLE;
				// Whole decision in one cycle, registered for the outputs
				if (i_req_valid) begin
					s_nxt.st       = PAC_ST_DONE;
					s_nxt.dram     = dram_sel;
					s_nxt.addr     = pa;
					s_nxt.enc      = enc_page && dram_sel;
					s_nxt.nxt_enc  = enc_page && (i_req_page == PAC_PG_TBL) &&
						!(i_legacy_32 && CBIT_POS >= 32);
					s_nxt.type_bad = !type_ok(
						pair_hit ? pair_rd : bnd_dram,
						pair_hit ? pair_wr : bnd_dram, i_req_type);
					s_nxt.pf       = enc_on && REDUCE_W && (upper_bits != '0);
					s_nxt.mce      = enc_page && !dram_sel;
				end
			end
			default: begin
				s_nxt.st = PAC_ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	// ==========================================================
	// Read side and identification
	assign o_cfg_rdata  = s_r.cfg;
	assign o_low_rdata  = {12'h000, s_r.low, 23'h0};
	assign o_high_rdata = {12'h000, s_r.high, 23'h0};
	// Feature leaf: support, coherency, bit position and width reduction
	always_comb begin
		o_feat_eax = 32'h0000_0000;
		o_feat_eax[`PAC_FEAT_SUPPORT]  = 1'b1;
		o_feat_eax[`PAC_FEAT_COHERENT] = COHERENT;
		o_feat_ebx = 32'h0000_0000;
		o_feat_ebx[5:0]  = 6'(CBIT_POS);
		o_feat_ebx[11:6] = REDUCE_W ? 6'(FULL_PA_W - RED_PA_W) : 6'h00;
	end

	assign o_req_ready    = 1'b1;
	assign o_rsp_valid    = (s_r.st == PAC_ST_DONE);
	assign o_rsp_dram     = s_r.dram;
	assign o_rsp_encrypt  = s_r.enc;
	assign o_rsp_next_enc = s_r.nxt_enc;
	assign o_rsp_type_bad = s_r.type_bad;
	assign o_rsp_pf       = s_r.pf;
	assign o_rsp_mce      = s_r.mce;
	assign o_rsp_addr     = s_r.addr;

	// Key leaves only on o_key; no register read port returns it
	pac_keyreg #(
		.KEY_W (`PAC_KEY_W)
	) u_key (
		.i_clk       (i_clk),
		.i_resetn    (i_resetn),
		.i_entropy   (i_entropy),
		.o_key_ready (o_key_ready),
		.o_key       (o_key)
	);
endmodule
`default_nettype wire

//--- design/pac_params.svh
// Constants for the physical-address classifier: field positions, widths and encodings
`ifndef PAC_PARAMS_SVH
`define PAC_PARAMS_SVH

`define PAC_ADDR_W        52
`define PAC_BND_HI        51
`define PAC_BND_LO        23
`define PAC_4G_BIT        32
`define PAC_CFG_LOW_EN    20
`define PAC_CFG_HIGH_EN   21
`define PAC_CFG_ENC_EN    23
`define PAC_WR_BIT        3
`define PAC_RD_BIT        4
`define PAC_VALID_BIT     11
`define PAC_RANGE_LO      12
`define PAC_NUM_PAIRS     2
`define PAC_FULL_PA_W     48
`define PAC_RED_PA_W      43
`define PAC_CBIT_POS      47
`define PAC_FEAT_SUPPORT  0
`define PAC_FEAT_COHERENT 10
`define PAC_TYPE_UC       3'h0
`define PAC_TYPE_WC       3'h1
`define PAC_TYPE_WT       3'h4
`define PAC_TYPE_WP       3'h5
`define PAC_TYPE_WB       3'h6
`define PAC_KEY_W         128
`define PAC_KEY_SEED      128'h5A5A_0F0F_3C3C_9696_A5A5_F0F0_C3C3_6969

`endif

//--- design/pac_pkg.sv
// Types shared by the physical-address classifier
package pac_pkg;
	typedef enum logic [1:0] {
		PAC_ST_IDLE = 2'b00,
		PAC_ST_LOOK = 2'b11,
		PAC_ST_DONE = 2'b01
	} pac_state_t;
	typedef enum logic [1:0] {
		PAC_PG_4K = 2'h0,
		PAC_PG_2M = 2'h1,
		PAC_PG_1G = 2'h2,
		PAC_PG_TBL = 2'h3
	} pac_page_t;
endpackage

//--- design/pac_keyreg.sv
// Boot-time random key register: generated at reset release, never readable by software
`timescale 1ns/1ns
`default_nettype none
`include "pac_params.svh"
module pac_keyreg #(
	parameter int KEY_W = `PAC_KEY_W
) (
	input  wire logic             i_clk,
	input  wire logic             i_resetn,
	input  wire logic             i_entropy,
	output logic                  o_key_ready,
	output logic [KEY_W-1:0]      o_key
);
	typedef struct packed {
		logic [KEY_W-1:0] key;
		logic [7:0]       cnt;
		logic             ready;
	} pac_key_state_t;

	pac_key_state_t s_r;
	pac_key_state_t s_nxt;

	// ==========================================================
	// Key generation
	// LFSR mixed with entropy for a fixed run after reset, then frozen
	always_comb begin
		s_nxt = s_r;
		if (!s_r.ready) begin
			s_nxt.key = {s_r.key[KEY_W-2:0],
				s_r.key[KEY_W-1] ^ s_r.key[KEY_W-3] ^ s_r.key[KEY_W-28] ^ i_entropy};
			s_nxt.cnt = s_r.cnt + 8'h01;
			if (s_r.cnt == 8'hFF) begin
				s_nxt.ready = 1'b1;
			end
		end
	end

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			s_r <= '{key: KEY_W'(`PAC_KEY_SEED), cnt: 8'h00, ready: 1'b0};
		end else begin
			s_r <= s_nxt;
		end
	end

	assign o_key_ready = s_r.ready;
	assign o_key       = s_r.key;
endmodule
`default_nettype wire

//--- sim/pac_fabric_model.sv
// Far-side model: memory controller and I/O fabric tallying routed accesses
`timescale 1ns/1ns
`default_nettype none
// ==========
// Fabric model
module pac_fabric_model (
	input  wire logic   i_clk,
	input  wire logic   i_resetn,
	input  wire logic   i_rsp_valid,
	input  wire logic   i_rsp_dram,
	output logic [15:0] o_dram_cnt,
	output logic [15:0] o_mmio_cnt
);
	// Each answer lands at one target only; a lost or doubled answer shows in the sum
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_dram_cnt <= 16'h0000;
			o_mmio_cnt <= 16'h0000;
		end else if (i_rsp_valid && i_rsp_dram) begin
			o_dram_cnt <= o_dram_cnt + 16'h0001;
		end else if (i_rsp_valid) begin
			o_mmio_cnt <= o_mmio_cnt + 16'h0001;
		end
	end
endmodule
`default_nettype wire

//--- sim/pac_classifier_properties.sv
// Port-level checks for the address classifier
`timescale 1ns/1ns
`default_nettype none
// ==========
// Checker
module pac_classifier_props (
	input wire logic        i_clk,
	input wire logic        i_resetn,
	input wire logic        i_low_we,
	input wire logic [63:0] i_bnd_wdata,
	input wire logic        i_req_valid,
	input wire logic [1:0]  i_req_page,
	input wire logic        i_legacy_32,
	input wire logic        i_paging_on,
	input wire logic [63:0] o_cfg_rdata,
	input wire logic [63:0] o_high_rdata,
	input wire logic [63:0] o_low_rdata,
	input wire logic [31:0] o_feat_eax,
	input wire logic        o_req_ready,
	input wire logic        o_rsp_valid,
	input wire logic        o_rsp_dram,
	input wire logic        o_rsp_encrypt,
	input wire logic        o_rsp_next_enc,
	input wire logic        o_rsp_mce
);
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_resetn);
	// Answer exactly one edge after the request, never unasked
	a_rsp_one_cycle: assert property (i_req_valid |=> o_rsp_valid)
		else $error("response missing");
	a_rsp_unasked: assert property (!i_req_valid |=> !o_rsp_valid)
		else $error("unrequested response");
	a_ready_always: assert property (o_req_ready)
		else $error("ready dropped");
	// Only the 8 MiB field survives a boundary write
	a_low_field: assert property (i_low_we |=>
		o_low_rdata == ($past(i_bnd_wdata) & 64'h000F_FFFF_FF80_0000))
		else $error("low boundary field wrong");
	a_high_rsvd: assert property (o_high_rdata[22:0] == 23'h0 && o_high_rdata[63:52] == 12'h0)
		else $error("high boundary reserved bits set");
	// Ciphering only toward memory; an encrypted MMIO hit is an error instead
	a_mce_mmio: assert property (o_rsp_valid && o_rsp_mce |-> !o_rsp_dram)
		else $error("machine check on memory target");
	a_enc_dram: assert property (o_rsp_valid && o_rsp_encrypt |-> o_rsp_dram)
		else $error("encrypt toward MMIO");
	a_enc_gate: assert property (i_req_valid && !(o_cfg_rdata[23] && i_paging_on) |=>
		!o_rsp_encrypt && !o_rsp_mce)
		else $error("encryption while disabled");
	a_next_page: assert property (i_req_valid && i_req_page != 2'h3 |=> !o_rsp_next_enc)
		else $error("table fetch flag on leaf");
	a_legacy_tbl: assert property (i_req_valid && i_legacy_32 |=> !o_rsp_next_enc)
		else $error("encrypted table in 32-bit mode");
	a_feat_bits: assert property (o_feat_eax[0] && !o_feat_eax[10])
		else $error("feature bits wrong");
endmodule
bind pac_classifier pac_classifier_props pac_classifier_props_i (.*);
`default_nettype wire

//--- sim/test_pac_classifier.sv
// Self-checking bench for the address classifier
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin failures++; \
	$display("ERROR %s expected %h seen %h", n, e, g); end end
// ==========
// Bench
module test_pac_classifier;
	logic        i_clk, i_resetn, i_entropy, i_cfg_we, i_low_we, i_high_we, i_req_valid;
	logic        i_req_write, i_req_cbit, i_addr_ext_on, i_paging_on, i_legacy_32, i_mgmt_mode;
	logic [63:0] i_cfg_wdata, i_bnd_wdata, i_pair_wdata, i_req_addr, o_cfg_rdata, o_low_rdata;
	logic [63:0] o_high_rdata, cfg, low, high, base[2], mask[2];
	logic [1:0]  i_base_we, i_mask_we, i_req_page;
	logic [2:0]  i_req_type, ty;
	logic [31:0] o_feat_eax, o_feat_ebx, rnd;
	logic        o_req_ready, o_rsp_valid, o_rsp_dram, o_rsp_encrypt, o_rsp_next_enc;
	logic        o_rsp_type_bad, o_rsp_pf, o_rsp_mce, o_key_ready;
	logic [51:0] o_rsp_addr;
	logic [127:0] o_key;
	logic [15:0] dram_cnt, mmio_cnt;
	logic [63:0] q[$], e;
	int          failures, n_tests, nreq;
	pac_classifier pac_classifier_i (.*);
	pac_fabric_model pac_fabric_model_i (.i_clk(i_clk), .i_resetn(i_resetn),
		.i_rsp_valid(o_rsp_valid), .i_rsp_dram(o_rsp_dram), .o_dram_cnt(dram_cnt),
		.o_mmio_cnt(mmio_cnt));
	initial begin
		i_clk = 1'b0;
		forever #50 i_clk = ~i_clk;
	end
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// Expected {address, next_enc, type_bad, pf, mce, encrypt, dram}; lower pair wins on overlap
	function automatic logic [57:0] model(input logic [63:0] ad, input logic w, c,
		input logic [1:0] pg);
		logic        on;
		logic        d;
		logic        r;
		logic        v;
		logic        ok;
		logic [63:0] a;
		on = cfg[23] && i_addr_ext_on && i_paging_on;
		a = on ? {21'h0, ad[42:0]} : {16'h0, ad[47:0]};
		d = (a < 64'h1_0000_0000) ? (cfg[20] && a < low) : (cfg[21] && a < high);
		{r, v} = {d, d};
		for (int k = 1; k >= 0; k--)
			if (mask[k][11] && ((a ^ base[k]) & mask[k] & 64'h000F_FFFF_FFFF_F000) == 0)
				{d, r, v} = {w ? base[k][3] : base[k][4], base[k][4], base[k][3]};
		// Allowed read and write target pairings with the memory type
		case ({r, v})
			2'h0: ok = ty inside {3'h0, 3'h1, 3'h4, 3'h5};
			2'h1: ok = ty inside {3'h0, 3'h1};
			2'h2: ok = ty inside {3'h0, 3'h5};
			default: ok = ty inside {3'h0, 3'h1, 3'h4, 3'h6};
		endcase
		return {a[51:0], c && on && pg == 2'h3 && !i_legacy_32, !ok,
			on && (|ad[63:48] || |ad[46:43]), c && on && !d, c && on && d, d};
	endfunction
	// One write strobe; k picks cfg, low, high, base0, base1, mask0, mask1
	task automatic wr(input int k, input logic [63:0] d);
		@(posedge i_clk);
		{i_cfg_wdata, i_bnd_wdata, i_pair_wdata} <= {d, d, d};
		{i_mask_we, i_base_we, i_high_we, i_low_we, i_cfg_we} <= 7'(1 << k);
		if (k == 0) cfg = d;
		if (k == 1) low = d & 64'h000F_FFFF_FF80_0000;
		if (k == 2) high = d & 64'h000F_FFFF_FF80_0000;
		if (k == 3 || k == 4) base[k - 3] = d;
		if (k >= 5) mask[k - 5] = d;
		@(posedge i_clk);
		{i_mask_we, i_base_we, i_high_we, i_low_we, i_cfg_we} <= 7'h00;
	endtask
	// Request held valid so successive calls go back to back
	task automatic req(input logic [63:0] a, input logic w, c, input logic [1:0] pg,
		input logic [5:0] m);
		logic [57:0] r;
		@(posedge i_clk);
		{i_req_valid, i_req_addr, i_req_write, i_req_cbit, i_req_page} <= {1'b1, a, w, c, pg};
		i_req_type <= ty;
		r = model(a, w, c, pg);
		q.push_back({r[57:6], m, r[5:0]});
		nreq++;
	endtask
	task automatic idle();
		@(posedge i_clk);
		i_req_valid <= 1'b0;
	endtask
	task automatic end_sim();
		if (failures == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	always @(posedge i_clk) i_entropy <= rnd[5];
	// Each answer retires the oldest note
	always @(negedge i_clk) begin
		if (o_rsp_valid && q.size() == 0)
			`CHK("queue", 1'b0, o_rsp_valid)
		else if (o_rsp_valid) begin
			e = q.pop_front();
			`CHK("dram", e[0] & e[6], o_rsp_dram & e[6])
			`CHK("encrypt", e[1] & e[7], o_rsp_encrypt & e[7])
			`CHK("mce", e[2] & e[8], o_rsp_mce & e[8])
			`CHK("fault", e[3] & e[9], o_rsp_pf & e[9])
			`CHK("type", e[4] & e[10], o_rsp_type_bad & e[10])
			`CHK("next enc", e[5] & e[11], o_rsp_next_enc & e[11])
			`CHK("address", e[63:12], o_rsp_addr)
		end
	end
	initial begin
		#2000000;
		failures++;
		end_sim();
	end
	initial begin
		static logic [63:0] adr[7] = '{64'h0, 64'h7FFF_FFFF, 64'h8000_0000, 64'hFFFF_FFFF,
			64'h1_0000_0000, 64'h1_7FFF_FFFF, 64'h1_8000_0000};
		static logic [63:0] cf[4] = '{64'h0, 64'h10_0000, 64'h20_0000, 64'h30_0000};
		{i_resetn, i_cfg_we, i_low_we, i_high_we, i_base_we, i_mask_we, i_req_valid, i_req_write,
			i_req_cbit, i_req_page, i_req_type, i_addr_ext_on, i_paging_on, i_legacy_32,
			i_mgmt_mode, i_cfg_wdata, i_bnd_wdata, i_pair_wdata, i_req_addr} = '0;
		{ty, cfg, low, high, failures, n_tests, nreq} = '0;
		base = '{default: 0};
		mask = '{default: 0};
		rnd = 32'hA01511B4;
		repeat (4) @(posedge i_clk);
		i_resetn <= 1'b1;
		@(negedge i_clk);
		`CHK("low reset", 64'h0, o_low_rdata)
		`CHK("id ebx", 12'h16F, o_feat_ebx[11:0])
		wr(1, '1);
		@(negedge i_clk);
		`CHK("low field", 64'h000F_FFFF_FF80_0000, o_low_rdata)
		wr(1, 64'h8000_0000);
		wr(2, 64'h1_8000_0000);
		@(negedge i_clk);
		`CHK("high", 64'h1_8000_0000, o_high_rdata)
		// Every enable combination against both edges of each boundary
		foreach (cf[j]) begin
			wr(0, cf[j]);
			foreach (adr[i]) req(adr[i], i[0], 1'b0, 2'h0, 6'h3F);
			idle();
		end
		// Pair 1 invalid first, then valid: target bits override the boundaries
		wr(3, 64'h4000_0010);
		wr(5, 64'h000F_FFFF_F000_0800);
		wr(4, 64'h1_0000_0008);
		wr(6, 64'h000F_FFFF_F000_0000);
		repeat (2) begin
			for (int i = 0; i < 4; i++) req(i[1] ? 64'h1_0000_2000 : 64'h4000_1000, i[0], 1'b0, 2'h0, 6'h3F);
			idle();
			wr(6, 64'h000F_FFFF_F000_0800);
		end
		for (int n = 0; n < 16; n++) begin
			rnd = lfsr(rnd);
			ty = rnd[6:4];
			req({31'h0, rnd[0], rnd[31:12], 12'h000}, rnd[1], 1'b0, rnd[3:2], 6'h3F);
		end
		idle();
		// Encryption on, management mode set; a hidden width fault checks only its flag and the address
		wr(0, 64'hB0_0000);
		@(negedge i_clk);
		`CHK("cfg", 64'hB0_0000, o_cfg_rdata)
		@(posedge i_clk);
		{i_addr_ext_on, i_paging_on, i_mgmt_mode} <= 3'b111;
		for (int p = 0; p < 4; p++) req(64'h1000, 1'b0, 1'b1, 2'(p), 6'h3F);
		req(64'h8000_0000_1000, 1'b1, 1'b1, 2'h0, 6'h3F);
		req(64'hF000_0000, 1'b1, 1'b1, 2'h0, 6'h3F);
		req(64'h1000_0000_1000, 1'b0, 1'b0, 2'h0, 6'h08);
		idle();
		@(posedge i_clk);
		i_legacy_32 <= 1'b1;
		req(64'h1000, 1'b0, 1'b1, 2'h3, 6'h3F);
		idle();
		@(posedge i_clk);
		{i_legacy_32, i_paging_on} <= 2'b00;
		req(64'hF000_0000, 1'b0, 1'b1, 2'h0, 6'h3F);
		idle();
		repeat (260) @(posedge i_clk);
		@(negedge i_clk);
		`CHK("pending", 0, q.size())
		`CHK("fabric", 16'(nreq), dram_cnt + mmio_cnt)
		`CHK("key ready", 1'b1, o_key_ready)
		end_sim();
	end
endmodule
`default_nettype wire
